// *** rtl/acg_aux_pin.sv ***
`timescale 1ns/1ps
// One auxiliary pin: general-purpose I/O or alternate input
module acg_aux_pin (
   input  wire logic mclk,
   input  wire logic resetn,
   input  wire logic function_gpio,
   input  wire logic dir_out,
   input  wire logic value,
   input  wire logic seq_active,
   input  wire logic seq_level,
   input  wire logic pin_in,
   output logic      pin_out,
   output logic      pin_oe,
   output logic      read_level
);
   logic next_pin_out;
   logic next_pin_oe;
   logic next_read_level;

   // Alternate function leaves the pin undriven whatever dir and value say
   always_comb begin
      next_pin_out    = 1'b0;
      next_pin_oe     = 1'b0;
      next_read_level = pin_in;                        // RULE_13
      if (function_gpio) begin                         // RULE_19
         if (seq_active) begin
            next_pin_oe  = 1'b1;                       // RULE_01
            next_pin_out = seq_level;
         end else if (dir_out) begin
            next_pin_oe     = 1'b1;                    // RULE_12
            next_pin_out    = value;                   // RULE_13
            next_read_level = value;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_out    <= 1'b0;
         pin_oe     <= 1'b0;
         read_level <= 1'b0;
      end else begin
         pin_out    <= next_pin_out;
         pin_oe     <= next_pin_oe;
         read_level <= next_read_level;
      end
   end
endmodule : acg_aux_pin

// *** rtl/acg_delay_timer.sv ***
`timescale 1ns/1ps
// Counts count * unit_cycles clocks after start, then pulses done
module acg_delay_timer
   import acg_pkg::*;
#(
   parameter logic [11:0] UNIT_CYCLES = 12'h001
) (
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       start,
   input  wire logic [7:0] count,
   output logic            busy,
   output logic            done
);
   logic [11:0] unit_cnt;
   logic [7:0]  ticks;
   logic [11:0] next_unit_cnt;
   logic [7:0]  next_ticks;
   logic        next_busy;
   logic        next_done;

   // A new start restarts the delay, so the last change always waits in full
   always_comb begin
      next_unit_cnt = unit_cnt;
      next_ticks    = ticks;
      next_busy     = busy;
      next_done     = 1'b0;
      if (start) begin
         next_unit_cnt = 12'h000;
         next_ticks    = count;
         next_busy     = (count != 8'h00);
         next_done     = (count == 8'h00);      // Zero count inserts no delay
      end else if (busy) begin
         if (unit_cnt == UNIT_CYCLES - 12'h001) begin
            next_unit_cnt = 12'h000;
            if (ticks == 8'h01) begin
               next_busy = 1'b0;
               next_done = 1'b1;
            end else begin
               next_ticks = ticks - 8'h01;
            end
         end else begin
            next_unit_cnt = unit_cnt + 12'h001;
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         unit_cnt <= 12'h000;
         ticks    <= 8'h00;
         busy     <= 1'b0;
         done     <= 1'b0;
      end else begin
         unit_cnt <= next_unit_cnt;
         ticks    <= next_ticks;
         busy     <= next_busy;
         done     <= next_done;
      end
   end
endmodule : acg_delay_timer

// *** rtl/acg_pkg.sv ***
package acg_pkg;
   // Register select codes on the host register port
   localparam logic [1:0]  ACG_SEL_CONV_CAL   = 2'h0;
   localparam logic [1:0]  ACG_SEL_AUX_PIN    = 2'h1;
   localparam logic [1:0]  ACG_SEL_DELAY      = 2'h2;
   localparam logic [1:0]  ACG_SEL_CHMAP_UP   = 2'h3;

   // Reset values
   localparam logic [7:0]  ACG_CONV_CAL_RST   = 8'h1C;
   localparam logic [7:0]  ACG_AUX_PIN_RST    = 8'h40;
   localparam logic [15:0] ACG_DELAY_RST      = 16'h0000;
   localparam logic [23:0] ACG_CHMAP_UP_RST   = 24'h000000;

   // Conversion and calibration control fields
   localparam int ACG_B_PIN_SEQ    = 6;
   localparam int ACG_B_SYNC       = 5;
   localparam int ACG_B_CAL_RB     = 4;
   localparam int ACG_B_SYS_GAIN   = 3;
   localparam int ACG_B_SYS_OFS    = 2;
   localparam int ACG_B_SELF_GAIN  = 1;
   localparam int ACG_B_SELF_OFS   = 0;

   // Auxiliary pin control fields
   localparam int ACG_B_PIN1_FN    = 7;
   localparam int ACG_B_PIN0_FN    = 6;
   localparam int ACG_B_DIR1       = 5;
   localparam int ACG_B_DIR0       = 4;
   localparam int ACG_B_VAL1       = 1;
   localparam int ACG_B_VAL0       = 0;

   // Delay fields
   localparam int ACG_MUX_DLY_LSB  = 8;
   localparam int ACG_SW_DLY_LSB   = 0;

   // Per-channel map entry (8 bits each, channel 3 in the low byte)
   localparam int ACG_CH_PINSEL_LSB = 5;
   localparam int ACG_CH_ORDER_LSB  = 2;
   localparam int ACG_CH_SCAN_EN    = 1;
   localparam int ACG_CH_PIN_EN     = 0;
   localparam int ACG_CH_BITS       = 8;
   localparam logic [2:0] ACG_FIRST_UPPER_CH = 3'h3;

   // Sequencer mode that honours the pin sequencing select
   localparam logic [1:0] ACG_SEQ_MODE3 = 2'h3;

   // Timing
   localparam int CLK_PERIOD_NS       = 10;
   localparam int MUX_DELAY_UNIT_NS   = 4000;
   localparam int SWITCH_DELAY_UNIT_NS = 20000;
   localparam logic [11:0] MUX_UNIT_CYCLES    = 12'(MUX_DELAY_UNIT_NS / CLK_PERIOD_NS);
   localparam logic [11:0] SWITCH_UNIT_CYCLES = 12'(SWITCH_DELAY_UNIT_NS / CLK_PERIOD_NS);
endpackage : acg_pkg

// *** rtl/acg_regs.sv ***
// Summary of operation
// (RULE_01) Mode 3 with sequencing select set: pins follow the per-channel map.
// (RULE_02) Select clear: output pins from direct register, aux pins from aux control.
// (RULE_03) In sequencer modes 1 and 2 the sequencing select is ignored.
// (RULE_04) Sync enable bit turns conversion synchronization mode on or off.
// (RULE_05) Calibration read returns host-written value if readback select set, else internal.
// (RULE_06) System gain bypass set drops system gain coefficient from correction.
// (RULE_07) System offset bypass set drops system offset coefficient from correction.
// (RULE_08) Self gain bypass set drops self-calibration gain coefficient.
// (RULE_09) Self offset bypass set drops self-calibration offset coefficient.
// (RULE_10) Pin1 function select: 1 general-purpose I/O, 0 sync input.
// (RULE_11) Pin0 function select: 1 general-purpose I/O, 0 external clock input.
// (RULE_12) Direction bit 1 makes aux pin output, 0 input; bit1 pin1, bit0 pin0.
// (RULE_13) Output pins drive their value bit; input pins read back the pin level.
// (RULE_14) Mux settle delay is 4 us per count, zero means no delay.
// (RULE_15) Output switch delay is 20 us per count, zero means no delay.
// (RULE_16) Channel map fields: scan enable, pin enable, scan order, paired pin.
// (RULE_17) Channel map writes are refused during an active conversion.
// (RULE_18) Reset loads defaults: system calibration bypassed, pin0 general-purpose I/O.
// (RULE_19) Alternate pin function makes direction and value bits irrelevant.
`timescale 1ns/1ps
module acg_regs
   import acg_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic [1:0]  reg_sel,
   input  wire logic        reg_wr,
   input  wire logic [23:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic      [23:0] reg_rdata,
   input  wire logic        conv_active,
   input  wire logic [1:0]  seq_mode,
   input  wire logic [2:0]  seq_channel,
   input  wire logic [23:0] chmap_lower,
   input  wire logic [1:0]  output_pin_direct_register,
   input  wire logic        mux_switch,
   input  wire logic [23:0] cal_host_value,
   input  wire logic [23:0] cal_internal_value,
   input  wire logic [1:0]  aux_pin_in,
   output logic      [1:0]  aux_pin_out,
   output logic      [1:0]  aux_pin_oe,
   output logic      [1:0]  switch_output_pin,
   output logic      [23:0] cal_read_value,
   output logic             sync_mode_en,
   output logic             sync_in,
   output logic             ext_clk_in,
   output logic             ext_clk_select,
   output logic             apply_system_gain,
   output logic             apply_system_offset,
   output logic             apply_self_gain,
   output logic             apply_self_offset,
   output logic             mux_settled,
   output logic             mux_busy,
   output logic             switch_busy,
   output logic      [23:0] scan_channel_map_upper
);
   logic [7:0]  conversion_calibration_control;
   logic [7:0]  aux_pin_control;
   logic [15:0] settling_delay;
   logic [7:0]  next_ccc;
   logic [7:0]  next_aux;
   logic [15:0] next_delay;
   logic [23:0] next_chmap;
   logic [23:0] next_rdata;
   logic [3:0]  pending_levels;
   logic [3:0]  applied_levels;
   logic [3:0]  next_pending;
   logic [3:0]  next_applied;
   logic [3:0]  target_levels;
   logic        sw_start;
   logic        sw_done;
   logic        sequenced;
   logic [7:0]  cur_entry;
   logic [1:0]  aux_read;
   logic [23:0] next_cal_read;
   logic [1:0]  next_switch_pin;
   logic [1:0]  next_sync_ext;
   logic [4:0]  next_ctl_out;

   // Map entry of one channel, from the upper or lower map register
   function automatic logic [7:0] chan_entry(input logic [2:0]  ch,
                                             input logic [23:0] lower,
                                             input logic [23:0] upper);
      logic [1:0] idx;
      idx = 2'h0;
      if (ch >= ACG_FIRST_UPPER_CH) begin
         idx = 2'(ch - ACG_FIRST_UPPER_CH);
         chan_entry = upper[idx*ACG_CH_BITS +: ACG_CH_BITS];
      end else begin
         idx = ch[1:0];
         chan_entry = lower[idx*ACG_CH_BITS +: ACG_CH_BITS];
      end
   endfunction : chan_entry

   // One-hot pin activation: 0 out0, 1 out1, 2 aux0, 3 aux1
   function automatic logic [3:0] pin_decode(input logic [7:0] entry);
      pin_decode = 4'h0;
      if (entry[ACG_CH_SCAN_EN] && entry[ACG_CH_PIN_EN]) begin
         pin_decode = 4'h1 << entry[ACG_CH_PINSEL_LSB +: 2];
      end
   endfunction : pin_decode

   // Register writes; map writes are dropped while converting
   always_comb begin
      next_ccc   = conversion_calibration_control;
      next_aux   = aux_pin_control;
      next_delay = settling_delay;
      next_chmap = scan_channel_map_upper;
      if (reg_wr) begin
         case (reg_sel)
            ACG_SEL_CONV_CAL: next_ccc   = {1'b0, reg_wdata[6:0]};
            ACG_SEL_AUX_PIN:  next_aux   = {reg_wdata[7:4], 2'b00, reg_wdata[1:0]};
            ACG_SEL_DELAY:    next_delay = reg_wdata[15:0];
            ACG_SEL_CHMAP_UP: begin
               if (!conv_active) begin                       // RULE_17
                  next_chmap = {1'b0, reg_wdata[22:16], 1'b0, reg_wdata[14:8],
                                1'b0, reg_wdata[6:0]};       // RULE_16
               end
            end
            default: next_ccc = conversion_calibration_control;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         conversion_calibration_control <= ACG_CONV_CAL_RST;  // RULE_18
         aux_pin_control                <= ACG_AUX_PIN_RST;   // RULE_18
         settling_delay                 <= ACG_DELAY_RST;
         scan_channel_map_upper         <= ACG_CHMAP_UP_RST;
      end else begin
         conversion_calibration_control <= next_ccc;
         aux_pin_control                <= next_aux;
         settling_delay                 <= next_delay;
         scan_channel_map_upper         <= next_chmap;
      end
   end

   // Read data; input aux pins show the sampled pin level, not the stored bit
   always_comb begin
      next_rdata = reg_rdata;
      if (reg_rd) begin
         case (reg_sel)
            ACG_SEL_CONV_CAL: next_rdata = {16'h0000, conversion_calibration_control};
            ACG_SEL_AUX_PIN:  next_rdata = {16'h0000, aux_pin_control[7:2], aux_read}; // RULE_13
            ACG_SEL_DELAY:    next_rdata = {8'h00, settling_delay};
            ACG_SEL_CHMAP_UP: next_rdata = scan_channel_map_upper;
            default:          next_rdata = 24'h000000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 24'h000000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

   // Pin sequencing only counts in mode 3
   assign sequenced = (seq_mode == ACG_SEQ_MODE3)
                      && conversion_calibration_control[ACG_B_PIN_SEQ];  // RULE_01 RULE_03
   assign cur_entry     = chan_entry(seq_channel, chmap_lower, scan_channel_map_upper);
   assign target_levels = sequenced ? pin_decode(cur_entry) : 4'h0;      // RULE_01

   // Changed targets wait out the switch delay before reaching the pins
   always_comb begin
      next_pending = pending_levels;
      next_applied = applied_levels;
      sw_start     = 1'b0;
      if (target_levels != pending_levels) begin
         next_pending = target_levels;
         sw_start     = 1'b1;                                            // RULE_15
      end
      if (sw_done) begin
         next_applied = pending_levels;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pending_levels <= 4'h0;
         applied_levels <= 4'h0;
      end else begin
         pending_levels <= next_pending;
         applied_levels <= next_applied;
      end
   end

   acg_delay_timer #(
      .UNIT_CYCLES (SWITCH_UNIT_CYCLES)
   ) u_switch_timer (
      .mclk   (mclk),
      .resetn (resetn),
      .start  (sw_start),
      .count  (settling_delay[ACG_SW_DLY_LSB +: 8]),                     // RULE_15
      .busy   (switch_busy),
      .done   (sw_done)
   );

   acg_delay_timer #(
      .UNIT_CYCLES (MUX_UNIT_CYCLES)
   ) u_mux_timer (
      .mclk   (mclk),
      .resetn (resetn),
      .start  (mux_switch),
      .count  (settling_delay[ACG_MUX_DLY_LSB +: 8]),                    // RULE_14
      .busy   (mux_busy),
      .done   (mux_settled)
   );

   acg_aux_pin u_aux0 (
      .mclk          (mclk),
      .resetn        (resetn),
      .function_gpio (aux_pin_control[ACG_B_PIN0_FN]),                   // RULE_11
      .dir_out       (aux_pin_control[ACG_B_DIR0]),                      // RULE_12
      .value         (aux_pin_control[ACG_B_VAL0]),
      .seq_active    (sequenced),
      .seq_level     (applied_levels[2]),
      .pin_in        (aux_pin_in[0]),
      .pin_out       (aux_pin_out[0]),
      .pin_oe        (aux_pin_oe[0]),
      .read_level    (aux_read[0])
   );

   acg_aux_pin u_aux1 (
      .mclk          (mclk),
      .resetn        (resetn),
      .function_gpio (aux_pin_control[ACG_B_PIN1_FN]),                   // RULE_10
      .dir_out       (aux_pin_control[ACG_B_DIR1]),                      // RULE_12
      .value         (aux_pin_control[ACG_B_VAL1]),
      .seq_active    (sequenced),
      .seq_level     (applied_levels[3]),
      .pin_in        (aux_pin_in[1]),
      .pin_out       (aux_pin_out[1]),
      .pin_oe        (aux_pin_oe[1]),
      .read_level    (aux_read[1])
   );

   // Control outputs and pin routing, registered so every output is a flop
   always_comb begin
      next_switch_pin = sequenced ? applied_levels[1:0]
                                  : output_pin_direct_register;          // RULE_02
      next_cal_read   = conversion_calibration_control[ACG_B_CAL_RB]
                        ? cal_host_value : cal_internal_value;           // RULE_05
      // Alternate inputs pass only when the pin is not a general-purpose I/O
      next_sync_ext   = {~aux_pin_control[ACG_B_PIN1_FN] & aux_pin_in[1],  // RULE_10
                         ~aux_pin_control[ACG_B_PIN0_FN] & aux_pin_in[0]}; // RULE_11
      next_ctl_out    = {conversion_calibration_control[ACG_B_SYNC],       // RULE_04
                         ~conversion_calibration_control[ACG_B_SYS_GAIN],  // RULE_06
                         ~conversion_calibration_control[ACG_B_SYS_OFS],   // RULE_07
                         ~conversion_calibration_control[ACG_B_SELF_GAIN], // RULE_08
                         ~conversion_calibration_control[ACG_B_SELF_OFS]}; // RULE_09
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         switch_output_pin   <= 2'h0;
         cal_read_value      <= 24'h000000;
         sync_in             <= 1'b0;
         ext_clk_in          <= 1'b0;
         ext_clk_select      <= 1'b0;
         sync_mode_en        <= 1'b0;
         apply_system_gain   <= 1'b0;
         apply_system_offset <= 1'b0;
         apply_self_gain     <= 1'b1;
         apply_self_offset   <= 1'b1;
      end else begin
         switch_output_pin   <= next_switch_pin;
         cal_read_value      <= next_cal_read;
         sync_in             <= next_sync_ext[1];
         ext_clk_in          <= next_sync_ext[0];
         ext_clk_select      <= ~aux_pin_control[ACG_B_PIN0_FN];
         sync_mode_en        <= next_ctl_out[4];
         apply_system_gain   <= next_ctl_out[3];
         apply_system_offset <= next_ctl_out[2];
         apply_self_gain     <= next_ctl_out[1];
         apply_self_offset   <= next_ctl_out[0];
      end
   end
endmodule : acg_regs

// *** testbench/acg_regs_asserts.sv ***
`timescale 1ns/1ps
// Watches the register port against the control outputs it drives
module acg_regs_asserts
   import acg_pkg::*;
(
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic [1:0]  reg_sel,
   input wire logic        reg_wr,
   input wire logic [23:0] reg_wdata,
   input wire logic        conv_active,
   input wire logic [1:0]  seq_mode,
   input wire logic [1:0]  output_pin_direct_register,
   input wire logic [1:0]  aux_pin_oe,
   input wire logic [1:0]  switch_output_pin,
   input wire logic        sync_mode_en,
   input wire logic        ext_clk_select,
   input wire logic        apply_system_gain,
   input wire logic        apply_system_offset,
   input wire logic        apply_self_gain,
   input wire logic        apply_self_offset,
   input wire logic [23:0] scan_channel_map_upper
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // Write to the conversion and calibration control register
   sequence ctl_wr_s;
      reg_wr && reg_sel == ACG_SEL_CONV_CAL;
   endsequence
   // Pin0 put on its alternate function, then left alone for a cycle
   sequence pin0_alt_s;
      reg_wr && reg_sel == ACG_SEL_AUX_PIN && !reg_wdata[ACG_B_PIN0_FN]
      ##1 !(reg_wr && reg_sel == ACG_SEL_AUX_PIN);
   endsequence
   sync_enable_a:
      assert property (ctl_wr_s |-> ##2 sync_mode_en == $past(reg_wdata[ACG_B_SYNC], 2))
      else $error("sync mode does not follow control write");
   sys_gain_a:
      assert property (ctl_wr_s |-> ##2 apply_system_gain != $past(reg_wdata[3], 2))
      else $error("system gain use wrong after write");
   sys_offset_a:
      assert property (ctl_wr_s |-> ##2 apply_system_offset != $past(reg_wdata[2], 2))
      else $error("system offset use wrong after write");
   self_gain_a:
      assert property (ctl_wr_s |-> ##2 apply_self_gain != $past(reg_wdata[1], 2))
      else $error("self gain use wrong after write");
   self_offset_a:
      assert property (ctl_wr_s |-> ##2 apply_self_offset != $past(reg_wdata[0], 2))
      else $error("self offset use wrong after write");
   map_refuse_a:
      assert property (reg_wr && reg_sel == ACG_SEL_CHMAP_UP && conv_active
                       |=> $stable(scan_channel_map_upper))
      else $error("channel map changed during conversion");
   alt_pin_quiet_a:
      assert property (pin0_alt_s |-> ##1 !aux_pin_oe[0])
      else $error("alternate function pin is driven");
   direct_pins_a:
      assert property ((seq_mode != ACG_SEQ_MODE3) [*2]
                       |=> switch_output_pin == $past(output_pin_direct_register))
      else $error("output pins not under direct control");
   reset_dflt_a:
      assert property ($rose(resetn) |-> apply_self_gain && apply_self_offset &&
                       !apply_system_gain && !apply_system_offset && !ext_clk_select)
      else $error("defaults wrong after reset");
endmodule : acg_regs_asserts

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import acg_pkg::*;
   logic        mclk, resetn, reg_wr, reg_rd, conv_active, mux_switch;
   logic [1:0]  reg_sel, seq_mode, output_pin_direct_register, aux_pin_in;
   logic [2:0]  seq_channel;
   logic [23:0] reg_wdata, reg_rdata, chmap_lower, cal_host_value, cal_internal_value;
   logic [1:0]  aux_pin_out, aux_pin_oe, switch_output_pin;
   logic [23:0] cal_read_value, scan_channel_map_upper;
   logic        sync_mode_en, sync_in, ext_clk_in, ext_clk_select, mux_settled;
   logic        apply_system_gain, apply_system_offset, apply_self_gain, apply_self_offset;
   logic        mux_busy, switch_busy;
   logic [7:0]  ctl_vals [4] = '{8'hFF, 8'h00, 8'h2A, 8'h55};
   logic [7:0]  m;
   int          fails, checks, n;

   acg_regs uut (.mclk, .resetn, .reg_sel, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
      .conv_active, .seq_mode, .seq_channel, .chmap_lower, .output_pin_direct_register,
      .mux_switch, .cal_host_value, .cal_internal_value, .aux_pin_in, .aux_pin_out,
      .aux_pin_oe, .switch_output_pin, .cal_read_value, .sync_mode_en, .sync_in,
      .ext_clk_in, .ext_clk_select, .apply_system_gain, .apply_system_offset,
      .apply_self_gain, .apply_self_offset, .mux_settled, .mux_busy, .switch_busy,
      .scan_channel_map_upper);

   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Compare and count; X matches only an X in the expected value
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Strobes are raised and dropped on falling edges, held across one rising edge
   task automatic wr(input logic [1:0] sel, input logic [23:0] data);
      @(negedge mclk);
      reg_sel   = sel;
      reg_wdata = data;
      reg_wr    = 1'b1;
      @(negedge mclk);
      reg_wr    = 1'b0;
   endtask : wr

   task automatic rd(input logic [1:0] sel, input logic [23:0] exp);
      @(negedge mclk);
      reg_sel = sel;
      reg_rd  = 1'b1;
      @(negedge mclk);
      reg_rd  = 1'b0;
      chk(reg_rdata, exp);
   endtask : rd

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      {resetn, reg_wr, reg_rd, conv_active, mux_switch} = 5'h00;
      {reg_sel, seq_mode, aux_pin_in, output_pin_direct_register} = 8'h01;
      {reg_wdata, chmap_lower, seq_channel} = 51'h0;
      cal_host_value = 24'h123456;
      cal_internal_value = 24'hABCDEF;
      fails = 0;
      checks = 0;
      repeat (16) @(negedge mclk);
      resetn = 1'b1;
      chk({18'h0, ext_clk_select, sync_mode_en, apply_system_gain, apply_system_offset,
           apply_self_gain, apply_self_offset}, 24'h3);
      rd(ACG_SEL_CONV_CAL, 24'h1C);
      rd(ACG_SEL_AUX_PIN, 24'h40);
      rd(ACG_SEL_DELAY, 24'h0);
      rd(ACG_SEL_CHMAP_UP, 24'h0);
      // Every control bit both ways; bit 7 is not writable
      foreach (ctl_vals[i]) begin
         m = ctl_vals[i] & 8'h7F;
         wr(ACG_SEL_CONV_CAL, {16'h0, ctl_vals[i]});
         @(negedge mclk);
         chk({19'h0, sync_mode_en, apply_system_gain, apply_system_offset, apply_self_gain,
              apply_self_offset}, {19'h0, m[5], ~m[3], ~m[2], ~m[1], ~m[0]});
         chk(cal_read_value, m[4] ? cal_host_value : cal_internal_value);
         rd(ACG_SEL_CONV_CAL, {16'h0, m});
      end
      // Aux pins as driven outputs, then inputs, then alternate functions
      wr(ACG_SEL_AUX_PIN, 24'hFF);
      @(negedge mclk);
      chk({20'h0, aux_pin_oe, aux_pin_out}, 24'hF);
      rd(ACG_SEL_AUX_PIN, 24'hF3);
      aux_pin_in = 2'b10;
      wr(ACG_SEL_AUX_PIN, 24'hC0);
      @(negedge mclk);
      chk({22'h0, aux_pin_oe}, 24'h0);
      rd(ACG_SEL_AUX_PIN, 24'hC2);
      chk({22'h0, sync_in, ext_clk_in}, 24'h0);
      wr(ACG_SEL_AUX_PIN, 24'h33);
      @(negedge mclk);
      chk({19'h0, ext_clk_select, aux_pin_oe, sync_in, ext_clk_in}, 24'h12);
      aux_pin_in = 2'b01;
      repeat (2) @(negedge mclk);
      chk({19'h0, ext_clk_select, aux_pin_oe, sync_in, ext_clk_in}, 24'h11);
      rd(ACG_SEL_AUX_PIN, 24'h31);
      wr(ACG_SEL_AUX_PIN, 24'hC0);
      // Delay fields, then mux settle time for a zero and a non-zero count
      wr(ACG_SEL_DELAY, 24'h1234);
      rd(ACG_SEL_DELAY, 24'h1234);
      for (int c = 0; c < 3; c += 2) begin
         wr(ACG_SEL_DELAY, 24'(c) << ACG_MUX_DLY_LSB);
         @(negedge mclk);
         mux_switch = 1'b1;
         @(negedge mclk);
         mux_switch = 1'b0;
         chk({23'h0, mux_busy}, 24'(c != 0));
         n = 1;
         while (mux_settled !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
         end
         if (n >= 3000) begin
            fails++;
            conclude();
         end
         chk(24'(n), 24'(1 + c * 400));
      end
      // Unwritable map bits, then a write refused during conversion
      wr(ACG_SEL_CHMAP_UP, 24'hFFFFFF);
      rd(ACG_SEL_CHMAP_UP, 24'h7F7F7F);
      conv_active = 1'b1;
      wr(ACG_SEL_CHMAP_UP, 24'h0);
      rd(ACG_SEL_CHMAP_UP, 24'h7F7F7F);
      chk(scan_channel_map_upper, 24'h7F7F7F);
      conv_active = 1'b0;
      // Channel 4 pairs with output pin 1, scan and pin enabled
      wr(ACG_SEL_CHMAP_UP, 24'h002300);
      wr(ACG_SEL_CONV_CAL, 24'h00);
      wr(ACG_SEL_DELAY, 24'h0);
      seq_mode = ACG_SEQ_MODE3;
      seq_channel = 3'h4;
      repeat (4) @(negedge mclk);
      chk({22'h0, switch_output_pin}, 24'h1);
      wr(ACG_SEL_CONV_CAL, 24'h40);
      repeat (4) @(negedge mclk);
      chk({22'h0, switch_output_pin}, 24'h2);
      seq_mode = 2'h1;
      repeat (3) @(negedge mclk);
      chk({22'h0, switch_output_pin}, 24'h1);
      // One switch delay count holds the new level back 2000 cycles
      wr(ACG_SEL_DELAY, 24'h0001);
      seq_channel = 3'h3;
      seq_mode = ACG_SEQ_MODE3;
      repeat (2100) @(negedge mclk);
      chk({22'h0, switch_output_pin}, 24'h0);
      seq_channel = 3'h4;
      repeat (1000) @(negedge mclk);
      chk({22'h0, switch_output_pin}, 24'h0);
      chk({23'h0, switch_busy}, 24'h1);
      repeat (1010) @(negedge mclk);
      chk({22'h0, switch_output_pin}, 24'h2);
      conclude();
   end
endmodule : tb_top

// Checker sees only the top-level ports
bind acg_regs acg_regs_asserts chk_i (.mclk, .resetn, .reg_sel, .reg_wr, .reg_wdata,
   .conv_active, .seq_mode, .output_pin_direct_register, .aux_pin_oe, .switch_output_pin,
   .sync_mode_en, .ext_clk_select, .apply_system_gain, .apply_system_offset,
   .apply_self_gain, .apply_self_offset, .scan_channel_map_upper);
